// >>> logic/nv_slave_pkg.sv
// Constants and types shared by the two-wire nonvolatile memory slave.
// Overview of operation
// [R1] Array holds 8192 bytes, serial access.
// [R2] Take 16-bit address, use low 13 bits.
// [R3] Master drives unused address bits as zero.
// [R4] Answer only when select bits match pins.
// [R5] Drive data after falls, sample on rises.
// [R6] Data line is open-drain: pull low only.
// [R7] Write-protect high blocks upper quarter writes.
// [R8] Write-protect low allows every location.
// [R9] Writes finish at bus speed, never busy.
// [R10] Commit each byte right after its transfer.
// [R11] Works at 100 kHz, 400 kHz, 1 MHz.
// [R12] Only a simple power-on reset exists.
// [R13] Address byte: type, select bits, read flag.
// [R14] Latch address, increment, wrap last to zero.
// [R15] Commit after eighth bit; start/stop aborts earlier.
// [R16] Reads continue while acked; writes always acked.
// [R17] Protected writes acked, address advances, unchanged.
`default_nettype none
package nv_slave_pkg;

  // Array geometry.
  localparam int          ADDR_W     = 13;
  localparam int          DATA_W     = 8;
  localparam int          DEPTH      = 8192;
  localparam logic [12:0] ADDR_LAST  = 13'h1fff;
  localparam logic [12:0] ADDR_ZERO  = 13'h0000;
  localparam logic [12:0] ADDR_ONE   = 13'h0001;

  // Slave address byte fields.
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SEL_MSB  = 3;
  localparam int SEL_LSB  = 1;
  localparam int RW_BIT   = 0;

  // Memory address byte fields: the high byte keeps only its low five bits.
  localparam int HI_USED_MSB = 4;

  // Upper quarter of the map, as seen in the two top address bits.
  localparam logic [1:0] PROT_QUARTER = 2'h3;

  // Bit counting within a byte.
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK  = 4'h8;

  // Input synchroniser: bit order is {wp, sel[2:0], sda, scl}; lines idle high.
  localparam int         SYNC_W   = 6;
  localparam logic [5:0] SYNC_RST = 6'h03;

  // Two-entry write buffer.
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_FULL  = 2'h2;
  localparam logic [1:0] BUF_ONE   = 2'h1;

  // Bus timing: fastest serial clock against the system clock.
  localparam int CLK_KHZ        = 40000;
  localparam int SCL_MAX_KHZ    = 1000;
  localparam int SCL_MIN_CYCLES = CLK_KHZ / SCL_MAX_KHZ;

  // Transaction states, Gray-coded along the write path.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEV     = 3'h1,
    ST_ADDR_HI = 3'h3,
    ST_ADDR_LO = 3'h2,
    ST_WDATA   = 3'h6,
    ST_RDATA   = 3'h7
  } state_t;

endpackage
`default_nettype wire

// >>> logic/byte_array.sv
// Byte-wide storage array with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module byte_array (
  // Clock.
  input  wire logic                            clk_in,
  // Write port.
  input  wire logic                            we_in,
  input  wire logic [nv_slave_pkg::ADDR_W-1:0] waddr_in,
  input  wire logic [nv_slave_pkg::DATA_W-1:0] wdata_in,
  // Read port.
  input  wire logic [nv_slave_pkg::ADDR_W-1:0] raddr_in,
  output logic      [nv_slave_pkg::DATA_W-1:0] rdata_out
);

  logic [nv_slave_pkg::DATA_W-1:0] mem_q [nv_slave_pkg::DEPTH];

  // Store one byte per cycle; contents survive any interface reset.
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in; // [R1]
    end
  end

  // Read data always come out of a register, one cycle after the address.
  always_ff @(posedge clk_in) begin
    rdata_out <= mem_q[raddr_in];
  end

endmodule
`default_nettype wire

// >>> logic/two_wire_nv_memory_slave.sv
// Two-wire bus slave giving serial byte access to a nonvolatile array.
`timescale 1ns/1ps
`default_nettype none
module two_wire_nv_memory_slave #(
  // Device-type field expected in the slave address; value is arbitrary.
  parameter logic [3:0] DEV_TYPE = 4'h5
) (
  // Clock and power-on reset.
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Two-wire bus pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // Straps.
  input  wire logic [2:0] device_select_pins_in,
  input  wire logic       write_protect_in
);

  logic                                 rst_meta_q;
  logic                                 rst_q;
  logic [nv_slave_pkg::SYNC_W-1:0]      sync1_q;
  logic [nv_slave_pkg::SYNC_W-1:0]      sync2_q;
  logic                                 scl_p_q;
  logic                                 sda_p_q;
  logic                                 scl_s;
  logic                                 sda_s;
  logic [2:0]                           sel_s;
  logic                                 wp_s;
  logic                                 rise;
  logic                                 fall;
  logic                                 start;
  logic                                 stop;
  nv_slave_pkg::state_t                 state_q;
  logic [3:0]                           cnt_q;
  logic                                 ack_q;
  logic                                 acking_q;
  logic                                 rw_q;
  logic [7:0]                           shift_q;
  logic [7:0]                           hi_q;
  logic [7:0]                           tx_q;
  logic                                 oe_n_q;
  logic [nv_slave_pkg::ADDR_W-1:0]      addr_q;
  logic                                 byte_done;
  logic [7:0]                           rx_byte;
  logic                                 dev_match;
  logic                                 prot;
  logic                                 push_v;
  logic                                 push_ready;
  logic                                 pop_v;
  logic [20:0]                          buf_q [2];
  logic                                 wr_ptr_q;
  logic                                 rd_ptr_q;
  logic [1:0]                           fill_q;
  logic [nv_slave_pkg::DATA_W-1:0]      rd_data;
  logic                                 go_read;

  // Power-on reset is applied at once and released through two flops.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0; // [R12]
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // Pins pass two flops; the fastest bus clock still gives many samples per bit.
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      sync1_q <= nv_slave_pkg::SYNC_RST; // [R11]
      sync2_q <= nv_slave_pkg::SYNC_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {write_protect_in, device_select_pins_in, sda_in, scl_in};
      sync2_q <= sync1_q;
      scl_p_q <= sync2_q[0];
      sda_p_q <= sync2_q[1];
    end
  end

  // Bus events from the synchronised lines.
  assign scl_s = sync2_q[0];
  assign sda_s = sync2_q[1];
  assign sel_s = sync2_q[4:2];
  assign wp_s  = sync2_q[5];
  assign rise  = scl_s & ~scl_p_q; // [R5]
  assign fall  = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Byte decode on the rising edge of the eighth bit.
  assign byte_done = rise & ~ack_q & (cnt_q == nv_slave_pkg::CNT_LAST)
                     & (state_q != nv_slave_pkg::ST_IDLE);
  assign rx_byte   = {shift_q[6:0], sda_s};
  assign dev_match = (rx_byte[nv_slave_pkg::TYPE_MSB:nv_slave_pkg::TYPE_LSB] == DEV_TYPE)
                     & (rx_byte[nv_slave_pkg::SEL_MSB:nv_slave_pkg::SEL_LSB] == sel_s); // [R4] [R13]
  assign prot      = wp_s & (addr_q[12:11] == nv_slave_pkg::PROT_QUARTER); // [R7] [R8]
  assign push_v    = byte_done & (state_q == nv_slave_pkg::ST_WDATA) & ~prot; // [R15] [R17]
  assign go_read   = (state_q == nv_slave_pkg::ST_RDATA)
                     | ((state_q == nv_slave_pkg::ST_DEV) & rw_q & acking_q);

  // Transaction sequencing; start and stop abort anything in progress.
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      state_q  <= nv_slave_pkg::ST_IDLE;
      cnt_q    <= nv_slave_pkg::CNT_ZERO;
      ack_q    <= 1'b0;
      acking_q <= 1'b0;
    end else if (start) begin
      state_q  <= nv_slave_pkg::ST_DEV; // [R15]
      cnt_q    <= nv_slave_pkg::CNT_ZERO;
      ack_q    <= 1'b0;
      acking_q <= 1'b0;
    end else if (stop) begin
      state_q  <= nv_slave_pkg::ST_IDLE;
      cnt_q    <= nv_slave_pkg::CNT_ZERO;
      ack_q    <= 1'b0;
      acking_q <= 1'b0;
    end else if (rise && !ack_q && state_q != nv_slave_pkg::ST_IDLE) begin
      cnt_q <= cnt_q + nv_slave_pkg::CNT_ONE;
      if (byte_done) begin
        case (state_q)
          nv_slave_pkg::ST_DEV: begin
            acking_q <= dev_match; // [R4]
            if (!dev_match) begin
              state_q <= nv_slave_pkg::ST_IDLE;
            end
          end
          nv_slave_pkg::ST_WDATA: acking_q <= push_ready; // [R16] [R17]
          nv_slave_pkg::ST_RDATA: acking_q <= 1'b0;
          default:                acking_q <= 1'b1;
        endcase
      end
    end else if (rise && ack_q && state_q == nv_slave_pkg::ST_RDATA && sda_s) begin
      state_q <= nv_slave_pkg::ST_IDLE; // [R16]
    end else if (fall && !ack_q && cnt_q == nv_slave_pkg::CNT_ACK) begin
      ack_q <= 1'b1;
    end else if (fall && ack_q) begin
      ack_q <= 1'b0;
      cnt_q <= nv_slave_pkg::CNT_ZERO;
      case (state_q)
        nv_slave_pkg::ST_DEV:
          state_q <= rw_q ? nv_slave_pkg::ST_RDATA : nv_slave_pkg::ST_ADDR_HI;
        nv_slave_pkg::ST_ADDR_HI: state_q <= nv_slave_pkg::ST_ADDR_LO;
        nv_slave_pkg::ST_ADDR_LO: state_q <= nv_slave_pkg::ST_WDATA;
        nv_slave_pkg::ST_WDATA:
          state_q <= acking_q ? nv_slave_pkg::ST_WDATA : nv_slave_pkg::ST_IDLE;
        nv_slave_pkg::ST_RDATA:   state_q <= nv_slave_pkg::ST_RDATA;
        default:                  state_q <= nv_slave_pkg::ST_IDLE;
      endcase
    end
  end

  // Incoming bits are shifted in most significant first on rising edges.
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      shift_q <= 8'h00;
      hi_q    <= 8'h00;
      rw_q    <= 1'b0;
    end else if (rise && !ack_q) begin
      shift_q <= rx_byte; // [R5]
      if (byte_done && state_q == nv_slave_pkg::ST_DEV) begin
        rw_q <= rx_byte[nv_slave_pkg::RW_BIT]; // [R13]
      end
      if (byte_done && state_q == nv_slave_pkg::ST_ADDR_HI) begin
        hi_q <= rx_byte;
      end
    end
  end

  // Address latch: loaded from two bytes, bumped after each data byte.
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      addr_q <= nv_slave_pkg::ADDR_ZERO;
    end else if (byte_done) begin
      case (state_q)
        nv_slave_pkg::ST_ADDR_LO:
          addr_q <= {hi_q[nv_slave_pkg::HI_USED_MSB:0], rx_byte}; // [R2] [R3]
        nv_slave_pkg::ST_WDATA, nv_slave_pkg::ST_RDATA:
          addr_q <= (addr_q == nv_slave_pkg::ADDR_LAST) ? nv_slave_pkg::ADDR_ZERO
                    : addr_q + nv_slave_pkg::ADDR_ONE; // [R14] [R17]
        default: addr_q <= addr_q;
      endcase
    end
  end

  // Open-drain driver: acknowledge pulls and read bits change after falls.
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      oe_n_q <= 1'b1;
      tx_q   <= 8'hff;
    end else if (start || stop) begin
      oe_n_q <= 1'b1;
    end else if (fall && !ack_q && cnt_q == nv_slave_pkg::CNT_ACK) begin
      oe_n_q <= ~(acking_q & (state_q != nv_slave_pkg::ST_IDLE)); // [R5] [R16]
    end else if (fall && ack_q) begin
      if (go_read) begin
        oe_n_q <= rd_data[7]; // [R14]
        tx_q   <= {rd_data[6:0], 1'b1};
      end else begin
        oe_n_q <= 1'b1;
      end
    end else if (fall && !ack_q && state_q == nv_slave_pkg::ST_RDATA
                 && cnt_q != nv_slave_pkg::CNT_ZERO) begin
      oe_n_q <= tx_q[7]; // [R5]
      tx_q   <= {tx_q[6:0], 1'b1};
    end
  end

  // The pin is only ever pulled low, never driven high.
  assign sda_out      = 1'b0; // [R6]
  assign sda_oe_n_out = oe_n_q;

  // Two-entry write buffer of {address, data}; the array drains it every cycle.
  assign push_ready = (fill_q != nv_slave_pkg::BUF_FULL);
  assign pop_v      = (fill_q != nv_slave_pkg::BUF_EMPTY);

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q   <= nv_slave_pkg::BUF_EMPTY;
    end else begin
      if (push_v && push_ready) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop_v) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if ((push_v && push_ready) && !pop_v) begin
        fill_q <= fill_q + nv_slave_pkg::BUF_ONE;
      end else if (!(push_v && push_ready) && pop_v) begin
        fill_q <= fill_q - nv_slave_pkg::BUF_ONE;
      end
    end
  end

  // Buffer storage needs no reset; fill count guards its use.
  always_ff @(posedge clk_in) begin
    if (push_v && push_ready) begin
      buf_q[wr_ptr_q] <= {addr_q, rx_byte}; // [R10]
    end
  end

  // Storage array; it accepts a buffered byte every cycle, so no busy time.
  byte_array u_array (
    .clk_in    (clk_in),
    .we_in     (pop_v), // [R9]
    .waddr_in  (buf_q[rd_ptr_q][20:8]),
    .wdata_in  (buf_q[rd_ptr_q][7:0]),
    .raddr_in  (addr_q),
    .rdata_out (rd_data)
  );

  // Checks on bus behaviour and the write path.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_q);

  a_pin_open_drain: assert property (sda_out == 1'b0) // [R6]
    else $error("Data pin driven high.");

  a_drive_after_fall: assert property ($changed(sda_oe_n_out) && !$past(start)
                                       && !$past(stop) |-> $past(fall)) // [R5]
    else $error("Data pin changed away from a falling clock edge.");

  a_protect_blocks: assert property (pop_v && wp_s
                                     |-> buf_q[rd_ptr_q][20:19] != nv_slave_pkg::PROT_QUARTER) // [R7]
    else $error("Write to protected quarter was committed.");

  a_unprot_commit: assert property (byte_done && state_q == nv_slave_pkg::ST_WDATA
                                    && !prot && push_ready |=> pop_v) // [R8]
    else $error("Permitted write did not reach the array.");

  a_commit_bound: assert property (push_v && push_ready |-> ##[1:2] pop_v) // [R10]
    else $error("Buffered byte not written in time.");

  a_addr_wrap: assert property (byte_done && state_q == nv_slave_pkg::ST_WDATA
                                && addr_q == nv_slave_pkg::ADDR_LAST
                                |=> addr_q == nv_slave_pkg::ADDR_ZERO) // [R14]
    else $error("Address did not wrap to zero.");

  a_addr_low_bits: assert property (byte_done && state_q == nv_slave_pkg::ST_ADDR_LO
                                    |=> addr_q == {$past(hi_q[4:0]), $past(rx_byte)}) // [R2]
    else $error("Address latch not loaded from low thirteen bits.");

  a_select_mismatch: assert property (byte_done && state_q == nv_slave_pkg::ST_DEV
                                      && !dev_match
                                      |=> state_q == nv_slave_pkg::ST_IDLE
                                          ##1 sda_oe_n_out [*3]) // [R4]
    else $error("Slave answered a foreign select address.");

  a_protect_acked: assert property (byte_done && state_q == nv_slave_pkg::ST_WDATA
                                    && prot && push_ready |=> acking_q) // [R17]
    else $error("Protected write not acknowledged.");

  a_start_abort: assert property (start |=> state_q == nv_slave_pkg::ST_DEV
                                  && sda_oe_n_out && cnt_q == nv_slave_pkg::CNT_ZERO) // [R15]
    else $error("Start did not restart the transaction.");

  c_write_byte: cover property (push_v);
  c_read_byte:  cover property (byte_done && state_q == nv_slave_pkg::ST_RDATA);
  c_prot_write: cover property (byte_done && state_q == nv_slave_pkg::ST_WDATA && prot);
  c_abort:      cover property (start && state_q == nv_slave_pkg::ST_WDATA);

endmodule
`default_nettype wire

// >>> dv/two_wire_master.sv
// Behavioural two-wire bus master that clocks the slave and drives its open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
  // Clock.
  input  wire logic clk_in,
  // Bus pins.
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // The clock idles driven high and the data line released, so the pull-up holds it high between frames.
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  // One quarter of the 200 ns bus clock period.
  task automatic quarter;
    repeat (2) @(posedge clk_in);
  endtask

  // Data moves only while the clock is low; the line is sampled in mid-high.
  task automatic bit_cycle(input logic b, output logic got);
    quarter();
    sda_oe_n_out <= b;
    quarter();
    scl_out <= 1'b1;
    quarter();
    got = sda_in;
    quarter();
    scl_out <= 1'b0;
  endtask

  // Start, also usable as a restart: data falls while the clock is high.
  task automatic start_cond;
    quarter();
    sda_oe_n_out <= 1'b1;
    quarter();
    scl_out <= 1'b1;
    quarter();
    sda_oe_n_out <= 1'b0;
    quarter();
    scl_out <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop_cond;
    quarter();
    sda_oe_n_out <= 1'b0;
    quarter();
    scl_out <= 1'b1;
    quarter();
    sda_oe_n_out <= 1'b1;
    quarter();
  endtask

  // Builds the slave address byte from type, select bits and direction.
  function automatic logic [7:0] addr_byte(input logic [3:0] dev, input logic [2:0] sel,
                                           input logic rd);
    return {dev, sel, rd};
  endfunction

  // Sends a byte MSB first and returns the acknowledge level seen on the ninth bit.
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], dummy);
    end
    bit_cycle(1'b1, ack_n);
  endtask

  // Receives a byte MSB first, then acknowledges or withholds acknowledge.
  task automatic recv_byte(input logic ack_n, output logic [7:0] d);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(ack_n, dummy);
  endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking testbench for the two-wire nonvolatile memory slave.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Device type is arbitrary; the select pins carry a fixed pattern.
  localparam logic [3:0] DEV_ID = 4'h9;
  localparam logic [2:0] PINS   = 3'h5;

  typedef struct packed {
    logic [7:0] whi;
    logic [7:0] rhi;
    logic [7:0] lo;
    logic [7:0] data;
    logic       wp;
    logic [7:0] exp;
  } row_t;

  logic       clk;
  logic       rst_n;
  logic       wp_q;
  logic [2:0] sel_q;
  logic       scl;
  logic       m_oe_n;
  logic       dut_sda;
  logic       dut_oe_n;
  logic       sda_line;
  logic       a;
  int         err_count;
  int         n_compared;
  int         cycles;
  row_t       rows [6];

  // Wired-AND data line with a pull-up.
  assign sda_line = (dut_oe_n ? 1'b1 : dut_sda) & m_oe_n;

  two_wire_nv_memory_slave #(.DEV_TYPE(DEV_ID)) dut_u (
    .clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(dut_sda),
    .sda_oe_n_out(dut_oe_n), .device_select_pins_in(sel_q), .write_protect_in(wp_q));

  two_wire_master master_u (
    .clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_oe_n_out(m_oe_n));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares a byte result.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a single line level such as an acknowledge.
  task automatic check_ack(input logic got, input logic exp);
    check({7'h00, got}, {7'h00, exp});
  endtask

  // Sends a byte that the slave must acknowledge.
  task automatic send(input logic [7:0] v);
    logic ack_n;
    master_u.send_byte(v, ack_n);
    check_ack(ack_n, 1'b0);
  endtask

  // Starts a write and loads the two memory address bytes.
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    master_u.start_cond();
    send(master_u.addr_byte(DEV_ID, PINS, 1'b0));
    send(hi);
    send(lo);
  endtask

  // Starts a read at the current address.
  task automatic rd_open;
    master_u.start_cond();
    send(master_u.addr_byte(DEV_ID, PINS, 1'b1));
  endtask

  // Reads one byte and compares it.
  task automatic rd(input logic ack_n, input logic [7:0] exp);
    logic [7:0] v;
    master_u.recv_byte(ack_n, v);
    check(v, exp);
  endtask

  // Ordinary cases as rows, then hand-written awkward cases.
  initial begin
    rst_n      = 1'b0;
    wp_q       = 1'b0;
    sel_q      = PINS;
    err_count  = 0;
    n_compared = 0;
    cycles     = 0;
    rows[0] = '{8'h18, 8'h18, 8'h00, 8'h11, 1'b0, 8'h11};
    rows[1] = '{8'h18, 8'h18, 8'h00, 8'h22, 1'b1, 8'h11};
    rows[2] = '{8'h17, 8'h17, 8'hff, 8'h33, 1'b1, 8'h33};
    rows[3] = '{8'hff, 8'h1f, 8'hfe, 8'h44, 1'b0, 8'h44};
    rows[4] = '{8'h1f, 8'h1f, 8'hfe, 8'h66, 1'b1, 8'h44};
    rows[5] = '{8'he0, 8'h00, 8'h05, 8'h55, 1'b0, 8'h55};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // The data line is released once reset is over.
    check_ack(dut_oe_n, 1'b1);
    // Write then re-address at once and read back.
    for (int i = 0; i < 6; i++) begin
      wp_q <= rows[i].wp;
      set_addr(rows[i].whi, rows[i].lo);
      send(rows[i].data);
      set_addr(rows[i].rhi, rows[i].lo);
      rd_open();
      rd(1'b1, rows[i].exp);
      master_u.stop_cond();
      check_ack(dut_sda, 1'b0);
    end
    // Every select pattern; only the strapped one is acknowledged.
    for (int s = 0; s < 8; s++) begin
      master_u.start_cond();
      master_u.send_byte(master_u.addr_byte(DEV_ID, 3'(s), 1'b0), a);
      check_ack(a, 3'(s) != PINS);
      master_u.stop_cond();
    end
    master_u.start_cond();
    master_u.send_byte(master_u.addr_byte(~DEV_ID, PINS, 1'b0), a);
    check_ack(a, 1'b1);
    master_u.stop_cond();
    // Burst across the top of the map, then random and current-address reads.
    wp_q <= 1'b0;
    set_addr(8'h1f, 8'hff);
    send(8'h66);
    send(8'h77);
    send(8'h88);
    master_u.stop_cond();
    set_addr(8'h1f, 8'hff);
    rd_open();
    rd(1'b0, 8'h66);
    rd(1'b1, 8'h77);
    master_u.stop_cond();
    rd_open();
    rd(1'b1, 8'h88);
    master_u.stop_cond();
    // A stop inside a data byte leaves the stored byte alone.
    set_addr(8'h01, 8'h00);
    send(8'h99);
    set_addr(8'h01, 8'h00);
    for (int j = 7; j >= 3; j--) begin
      master_u.bit_cycle(j[0], a);
    end
    master_u.stop_cond();
    set_addr(8'h01, 8'h00);
    rd_open();
    rd(1'b1, 8'h99);
    master_u.stop_cond();
    // Reset in mid-read releases the line; the slave works again after it.
    set_addr(8'h1f, 8'hff);
    rd_open();
    master_u.bit_cycle(1'b1, a);
    check_ack(a, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check_ack(dut_oe_n, 1'b1);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    master_u.stop_cond();
    set_addr(8'h1f, 8'hff);
    rd_open();
    rd(1'b1, 8'h66);
    master_u.stop_cond();
    end_of_test();
  end
endmodule
`default_nettype wire
